// ---- spz_cfg.svh ----
// constants for the serial port zero block
// assumes an 8-bit special-function register port and one system clock
//
// Contract
// - mode bit picks 8-bit or 9-bit framing
// - 8-bit frame: start, 8 data lsb-first, stop
// - 8-bit receive: stop level into ninth_rx_bit
// - data buffer write starts transmission at once
// - tx_done_flag set at stop bit start
// - receiver starts frames only while enabled
// - 8-bit accept: rx done clear, stop checked if mce set
// - overrun keeps first byte, drops later frame
// - accept loads byte, ninth bit, done flag
// - interrupt when either done flag set, enabled
// - 9-bit frame: start, 8 data, ninth, stop
// - 9-bit transmit sends ninth_tx_bit as ninth
// - 9-bit receive stores ninth, ignores stop
// - 9-bit accept: rx done clear, ninth checked if mce set
// - control bit 6 reads one, ignores writes
// - rx done at stop sample; software clears flags
// - baud timer may run from external oscillator
// - bit clocks are halved 8-bit reload overflows
// - start condition forces receive timer reload
// - buffer writes go tx, reads return rx
`ifndef SPZ_CFG_SVH
`define SPZ_CFG_SVH

// ---------------------------------------------
// register addresses and fields
// ---------------------------------------------
`define SPZ_ADDR_CONTROL 8'h98
`define SPZ_ADDR_DATA 8'h99
`define SPZ_BIT_MODE 7
`define SPZ_BIT_UNUSED 6
`define SPZ_BIT_MCE 5
`define SPZ_BIT_REN 4
`define SPZ_BIT_TB8 3
`define SPZ_BIT_RB8 2
`define SPZ_BIT_TI 1
`define SPZ_BIT_RI 0
`define SPZ_CTRL_RESET 8'h40
`define SPZ_BYTE_ZERO 8'h00

// ---------------------------------------------
// framing and timer
// ---------------------------------------------
`define SPZ_LAST_DATA 3'h7
`define SPZ_CNT_ZERO 3'h0
`define SPZ_CNT_ONE 3'h1
`define SPZ_SYNC_IDLE 3'h7
`define SPZ_TMR_MAX 8'hff
`define SPZ_TMR_ONE 8'h01

`endif

// ---- spz_pkg.sv ----
// types for the serial port zero block
// assumes spz_cfg.svh supplies the numeric constants
package spz_pkg;

  // ---------------------------------------------
  // register port request
  // ---------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } spz_sfr_req_t;

  // ---------------------------------------------
  // shifter states
  // ---------------------------------------------
  typedef enum logic [2:0] {
    tx_idle,
    tx_start,
    tx_data,
    tx_ninth,
    tx_stop
  } spz_tx_state_t;

  typedef enum logic [2:0] {
    rx_idle,
    rx_start,
    rx_data,
    rx_ninth,
    rx_stop
  } spz_rx_state_t;

endpackage

// ---- spz_serial_port.sv ----
// serial port zero: 8/9-bit asynchronous port with baud timers
// assumes a cpu register port on mclk and a timer clock enable on mclk
`include "spz_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module spz_serial_port
  import spz_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire spz_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic sys_baud_tick,
  input wire logic ext_osc_pin,
  input wire logic baud_src_ext,
  input wire logic baud_timer_run,
  input wire logic [7:0] baud_reload_value,
  input wire logic port_irq_enable,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic port_irq
);

  // ---------------------------------------------
  // declarations
  // ---------------------------------------------
  logic [2:0] ext_sync_r;
  logic [2:0] ext_sync_nxt;
  logic [2:0] rxd_sync_r;
  logic [2:0] rxd_sync_nxt;
  logic [7:0] tx_cnt_r;
  logic [7:0] tx_cnt_nxt;
  logic [7:0] rx_cnt_r;
  logic [7:0] rx_cnt_nxt;
  logic tmr_tick;
  logic tx_ovf;
  logic rx_ovf;
  logic rx_start_det;
  logic rx_fall;
  logic rxd;

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic wr_ctrl;
  logic wr_data;

  spz_tx_state_t tx_state_r;
  spz_tx_state_t tx_state_nxt;
  logic [7:0] tx_shift_r;
  logic [7:0] tx_shift_nxt;
  logic [2:0] tx_bit_r;
  logic [2:0] tx_bit_nxt;
  logic tx_half_r;
  logic tx_half_nxt;
  logic tx_out_r;
  logic tx_out_nxt;
  logic tx_bit_tick;
  logic set_ti;

  spz_rx_state_t rx_state_r;
  spz_rx_state_t rx_state_nxt;
  logic [7:0] rx_shift_r;
  logic [7:0] rx_shift_nxt;
  logic [7:0] rx_buf_r;
  logic [7:0] rx_buf_nxt;
  logic [2:0] rx_bit_r;
  logic [2:0] rx_bit_nxt;
  logic rx_half_r;
  logic rx_half_nxt;
  logic rx_ninth_r;
  logic rx_ninth_nxt;
  logic rx_mid;
  logic rx_load;
  logic rx_check_bit;

  // ---------------------------------------------
  // pin synchronisers and baud timers
  // ---------------------------------------------
  always_comb
  begin
    ext_sync_nxt = {ext_sync_r[1:0], ext_osc_pin};
    rxd_sync_nxt = {rxd_sync_r[1:0], serial_in_pin};
    rxd = rxd_sync_r[1];
    rx_fall = rxd_sync_r[2] & ~rxd_sync_r[1];
    // timer may count external oscillator edges
    tmr_tick = baud_src_ext ? (ext_sync_r[1] & ~ext_sync_r[2]) : sys_baud_tick;
    tx_cnt_nxt = tx_cnt_r;
    tx_ovf = 1'b0;
    if (baud_timer_run && tmr_tick)
    begin
      if (tx_cnt_r == `SPZ_TMR_MAX)
      begin
        tx_cnt_nxt = baud_reload_value;
        tx_ovf = 1'b1;
      end
      else
      begin
        tx_cnt_nxt = tx_cnt_r + `SPZ_TMR_ONE;
      end
    end
    rx_cnt_nxt = rx_cnt_r;
    rx_ovf = 1'b0;
    if (rx_start_det)
    begin
      rx_cnt_nxt = baud_reload_value;
    end
    else if (baud_timer_run && tmr_tick)
    begin
      if (rx_cnt_r == `SPZ_TMR_MAX)
      begin
        rx_cnt_nxt = baud_reload_value;
        rx_ovf = 1'b1;
      end
      else
      begin
        rx_cnt_nxt = rx_cnt_r + `SPZ_TMR_ONE;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ext_sync_r <= `SPZ_CNT_ZERO;
      rxd_sync_r <= `SPZ_SYNC_IDLE;
      tx_cnt_r <= `SPZ_BYTE_ZERO;
      rx_cnt_r <= `SPZ_BYTE_ZERO;
    end
    else
    begin
      ext_sync_r <= ext_sync_nxt;
      rxd_sync_r <= rxd_sync_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // ---------------------------------------------
  // control register and register port
  // ---------------------------------------------
  always_comb
  begin
    wr_ctrl = sfr_req.wr && (sfr_req.addr == `SPZ_ADDR_CONTROL);
    wr_data = sfr_req.wr && (sfr_req.addr == `SPZ_ADDR_DATA);
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      ctrl_nxt = sfr_req.wdata;
    end
    ctrl_nxt[`SPZ_BIT_UNUSED] = 1'b1;
    // hardware sets win over a same-cycle software clear
    if (set_ti)
    begin
      ctrl_nxt[`SPZ_BIT_TI] = 1'b1;
    end
    if (rx_load)
    begin
      ctrl_nxt[`SPZ_BIT_RB8] = rx_check_bit;
      ctrl_nxt[`SPZ_BIT_RI] = 1'b1;
    end
    rdata_nxt = rdata_r;
    if (sfr_req.rd)
    begin
      if (sfr_req.addr == `SPZ_ADDR_CONTROL)
      begin
        rdata_nxt = ctrl_r;
      end
      else if (sfr_req.addr == `SPZ_ADDR_DATA)
      begin
        rdata_nxt = rx_buf_r;
      end
      else
      begin
        rdata_nxt = `SPZ_BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl_r <= `SPZ_CTRL_RESET;
      rdata_r <= `SPZ_BYTE_ZERO;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  // flags only drop by software writes
  assign port_irq = port_irq_enable & (ctrl_r[`SPZ_BIT_TI] | ctrl_r[`SPZ_BIT_RI]);

  // ---------------------------------------------
  // transmitter
  // ---------------------------------------------
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    tx_shift_nxt = tx_shift_r;
    tx_bit_nxt = tx_bit_r;
    tx_out_nxt = tx_out_r;
    tx_half_nxt = tx_ovf ? ~tx_half_r : tx_half_r;
    tx_bit_tick = tx_ovf & tx_half_r;
    set_ti = 1'b0;
    if (wr_data)
    begin
      tx_state_nxt = tx_start;
      tx_shift_nxt = sfr_req.wdata;
      tx_bit_nxt = `SPZ_CNT_ZERO;
      tx_half_nxt = 1'b0;
      tx_out_nxt = 1'b0;
    end
    else if (tx_bit_tick)
    begin
      unique case (tx_state_r)
        tx_idle:
        begin
          tx_out_nxt = 1'b1;
        end
        tx_start:
        begin
          tx_state_nxt = tx_data;
          tx_out_nxt = tx_shift_r[0];
          tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
        end
        tx_data:
        begin
          if (tx_bit_r == `SPZ_LAST_DATA)
          begin
            if (ctrl_r[`SPZ_BIT_MODE])
            begin
              tx_state_nxt = tx_ninth;
              tx_out_nxt = ctrl_r[`SPZ_BIT_TB8];
            end
            else
            begin
              tx_state_nxt = tx_stop;
              tx_out_nxt = 1'b1;
              set_ti = 1'b1;
            end
          end
          else
          begin
            tx_bit_nxt = tx_bit_r + `SPZ_CNT_ONE;
            tx_out_nxt = tx_shift_r[0];
            tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
          end
        end
        tx_ninth:
        begin
          tx_state_nxt = tx_stop;
          tx_out_nxt = 1'b1;
          set_ti = 1'b1;
        end
        tx_stop:
        begin
          tx_state_nxt = tx_idle;
          tx_out_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tx_state_r <= tx_idle;
      tx_shift_r <= `SPZ_BYTE_ZERO;
      tx_bit_r <= `SPZ_CNT_ZERO;
      tx_half_r <= 1'b0;
      tx_out_r <= 1'b1;
    end
    else
    begin
      tx_state_r <= tx_state_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_half_r <= tx_half_nxt;
      tx_out_r <= tx_out_nxt;
    end
  end

  assign serial_out_pin = tx_out_r;

  // ---------------------------------------------
  // receiver
  // ---------------------------------------------
  always_comb
  begin
    rx_state_nxt = rx_state_r;
    rx_shift_nxt = rx_shift_r;
    rx_buf_nxt = rx_buf_r;
    rx_bit_nxt = rx_bit_r;
    rx_ninth_nxt = rx_ninth_r;
    rx_half_nxt = rx_ovf ? ~rx_half_r : rx_half_r;
    // first overflow after reload lands mid-bit
    rx_mid = rx_ovf & ~rx_half_r;
    rx_start_det = 1'b0;
    rx_load = 1'b0;
    // stop level in 8-bit mode, ninth bit in 9-bit mode
    rx_check_bit = ctrl_r[`SPZ_BIT_MODE] ? rx_ninth_r : rxd;
    unique case (rx_state_r)
      rx_idle:
      begin
        if (ctrl_r[`SPZ_BIT_REN] && rx_fall)
        begin
          rx_start_det = 1'b1;
          rx_state_nxt = rx_start;
          rx_half_nxt = 1'b0;
          rx_bit_nxt = `SPZ_CNT_ZERO;
        end
      end
      rx_start:
      begin
        if (rx_mid)
        begin
          rx_state_nxt = rxd ? rx_idle : rx_data;
        end
      end
      rx_data:
      begin
        if (rx_mid)
        begin
          rx_shift_nxt = {rxd, rx_shift_r[7:1]};
          rx_bit_nxt = rx_bit_r + `SPZ_CNT_ONE;
          if (rx_bit_r == `SPZ_LAST_DATA)
          begin
            rx_state_nxt = ctrl_r[`SPZ_BIT_MODE] ? rx_ninth : rx_stop;
          end
        end
      end
      rx_ninth:
      begin
        if (rx_mid)
        begin
          rx_ninth_nxt = rxd;
          rx_state_nxt = rx_stop;
        end
      end
      rx_stop:
      begin
        if (rx_mid)
        begin
          rx_state_nxt = rx_idle;
          // busy flag blocks overrun; filter checks stop or ninth
          if (!ctrl_r[`SPZ_BIT_RI] && (!ctrl_r[`SPZ_BIT_MCE] || rx_check_bit))
          begin
            rx_load = 1'b1;
            rx_buf_nxt = rx_shift_r;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rx_state_r <= rx_idle;
      rx_shift_r <= `SPZ_BYTE_ZERO;
      rx_buf_r <= `SPZ_BYTE_ZERO;
      rx_bit_r <= `SPZ_CNT_ZERO;
      rx_half_r <= 1'b0;
      rx_ninth_r <= 1'b0;
    end
    else
    begin
      rx_state_r <= rx_state_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_half_r <= rx_half_nxt;
      rx_ninth_r <= rx_ninth_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- spz_checker.sv ----
// assertions on the serial port pins and register port
// assumes the bind at the foot and 2-cycle bits for the frame check
`include "spz_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module spz_checker
  import spz_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire spz_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sys_baud_tick,
  input wire logic baud_src_ext,
  input wire logic baud_timer_run,
  input wire logic [7:0] baud_reload_value,
  input wire logic port_irq_enable,
  input wire logic serial_out_pin,
  input wire logic port_irq
);
  // ---------------------------------------------
  // helpers and properties
  // ---------------------------------------------
  logic dat_wr, ctl_wr, ctl_rd, far_rd, fast;
  logic [7:0] byte_r, byte_nxt;
  assign dat_wr = sfr_req.wr && sfr_req.addr == `SPZ_ADDR_DATA;
  assign ctl_wr = sfr_req.wr && sfr_req.addr == `SPZ_ADDR_CONTROL;
  assign ctl_rd = sfr_req.rd && sfr_req.addr == `SPZ_ADDR_CONTROL;
  assign far_rd = sfr_req.rd && !ctl_rd && sfr_req.addr != `SPZ_ADDR_DATA;
  logic [8:0] warm_r;
  logic raw_fast;
  assign raw_fast = sys_baud_tick && baud_timer_run && !baud_src_ext && baud_reload_value == 8'hff;
  // tx timer needs 256 fast ticks before overflows come back to back
  assign fast = raw_fast && warm_r[8];
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !raw_fast)
      warm_r <= 9'h000;
    else if (!warm_r[8])
      warm_r <= warm_r + 9'h001;
  end
  assign byte_nxt = dat_wr ? sfr_req.wdata : byte_r;
  always_ff @(posedge mclk)
  begin
    byte_r <= byte_nxt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_start_bit;
    (!serial_out_pin) [*2];
  endsequence
  sequence s_low_bits;
    (serial_out_pin == byte_r[0]) [*2] ##1 (serial_out_pin == byte_r[1]) [*2];
  endsequence
  property p_irq_gate;
    !port_irq_enable |-> !port_irq;
  endproperty
  property p_tx_start;
    dat_wr |=> !serial_out_pin;
  endproperty
  property p_tx_frame;
    dat_wr && fast |=> s_start_bit ##1 s_low_bits;
  endproperty
  property p_bit6;
    ctl_rd |=> sfr_rdata[6];
  endproperty
  property p_unmapped;
    far_rd |=> sfr_rdata == 8'h00;
  endproperty
  property p_rd_hold;
    !sfr_req.rd |=> $stable(sfr_rdata);
  endproperty
  property p_irq_hold;
    port_irq && !ctl_wr |=> port_irq || !port_irq_enable;
  endproperty
  property p_irq_flag;
    ctl_rd && !sfr_req.wr && port_irq_enable |=> port_irq || sfr_rdata[1:0] == 2'b00;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  a_tx_frame: assert property (p_tx_frame) else $error("bad frame head");
  a_bit6: assert property (p_bit6) else $error("bit 6 low");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
  a_irq_flag: assert property (p_irq_flag) else $error("irq vs flags");
endmodule
bind spz_serial_port spz_checker u_chk (
  .mclk(mclk),
  .reset_n(reset_n),
  .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata),
  .sys_baud_tick(sys_baud_tick),
  .baud_src_ext(baud_src_ext),
  .baud_timer_run(baud_timer_run),
  .baud_reload_value(baud_reload_value),
  .port_irq_enable(port_irq_enable),
  .serial_out_pin(serial_out_pin),
  .port_irq(port_irq)
);
`default_nettype wire

// ---- spz_far_uart.sv ----
// remote serial port: sends frames to the block, captures its frames
// assumes bits of BIT_CYC clocks and a line idling high
`timescale 1ns/10ps
`default_nettype none
module spz_far_uart #(
  parameter int BIT_CYC = 2
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out,
  input wire logic nine_mode
);
  // ---------------------------------------------
  // capture and send
  // ---------------------------------------------
  logic [9:0] got = '1;
  int got_cnt = 0;
  initial line_out = 1'b1;
  always
  begin
    @(posedge mclk iff line_in === 1'b0);
    got = '1;
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < (nine_mode ? 10 : 9); i++)
    begin
      got[i] = line_in;
      repeat (BIT_CYC) @(posedge mclk);
    end
    got_cnt++;
  end
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge mclk);
    line_out <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= bits[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    line_out <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge mclk);
  endtask
  task automatic glitch();
    @(posedge mclk);
    line_out <= 1'b0;
    @(posedge mclk);
    line_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test_spz_serial_port.sv ----
// self-checking bench for spz_serial_port
// assumes spz_far_uart as remote port, 2-cycle bits
`include "spz_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module test_spz_serial_port import spz_pkg::*;;
  // ---------------------------------------------
  // stimulus and checks
  // ---------------------------------------------
  localparam logic [7:0] ctl_a = `SPZ_ADDR_CONTROL;
  localparam logic [7:0] dat_a = `SPZ_ADDR_DATA;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  spz_sfr_req_t req = '0;
  logic ext_osc = 1'b0;
  logic pie = 1'b0;
  logic nine = 1'b0;
  logic ext_sel = 1'b0;
  logic [7:0] reload = 8'hff;
  logic rxd, txd, irq;
  logic [7:0] rdata, v;
  int bad_count = 0;
  int checks_done = 0;
  int n0;
  logic [7:0] rc [8] = '{8'h00, 8'h10, 8'h11, 8'h30, 8'h30, 8'hb0, 8'hb0, 8'h90};
  logic [9:0] rb [8] = '{10'h35a, 10'h33c, 10'h377, 10'h281, 10'h381, 10'h242, 10'h124, 10'h299};
  logic [7:0] re [8] = '{8'h40, 8'h55, 8'h51, 8'h70, 8'h75, 8'hf0, 8'hf5, 8'hd1};
  logic [7:0] rdt [8] = '{8'h00, 8'h3c, 8'h3c, 8'h3c, 8'h81, 8'h81, 8'h24, 8'h99};
  always #4 mclk = ~mclk;
  always @(posedge mclk) ext_osc <= ~ext_osc;
  spz_serial_port u_dut (.mclk(mclk), .reset_n(reset_n), .sfr_req(req), .sfr_rdata(rdata),
    .sys_baud_tick(1'b1), .ext_osc_pin(ext_osc), .baud_src_ext(ext_sel), .baud_timer_run(1'b1),
    .baud_reload_value(reload), .port_irq_enable(pie), .serial_in_pin(rxd),
    .serial_out_pin(txd), .port_irq(irq));
  spz_far_uart u_far (.mclk(mclk), .line_in(txd), .line_out(rxd), .nine_mode(nine));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_ev(input logic on_irq);
    for (int k = 0; k < 100; k++)
    begin
      @(posedge mclk);
      #1;
      if (on_irq ? irq === 1'b1 : u_far.got_cnt != n0)
        return;
    end
    bad_count++;
    $display("wrong value at %0t: no event in time", $time);
    give_verdict();
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(ctl_a, v);
    check(10'(v), 10'h040);
    rd(dat_a, v);
    check(10'(v), 10'h000);
    rd(8'h9a, v);
    check(10'(v), 10'h000);
    repeat (260) @(posedge mclk);
    pie <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      nine = m != 0;
      wr(ctl_a, {nine, 3'b000, m == 1, 3'b000});
      n0 = u_far.got_cnt;
      check(10'(irq), 10'h000);
      wr(dat_a, 8'ha5 ^ 8'(m));
      wait_ev(1'b1);
      check({txd, 9'(u_far.got_cnt - n0)}, 10'h200);
      wait_ev(1'b0);
      check(u_far.got, {1'b1, nine ? m == 1 : 1'b1, 8'ha5 ^ 8'(m)});
      rd(ctl_a, v);
      check(10'(v), {2'b00, nine, 3'b100, m == 1, 3'b010});
    end
    for (int s = 0; s < 2; s++)
    begin
      wr(ctl_a, 8'h00);
      @(posedge mclk);
      ext_sel <= s == 0;
      reload <= (s == 0) ? 8'hff : 8'hfe;
      wr(dat_a, 8'hff);
      repeat (30) @(posedge mclk);
      #1;
      check(10'(irq), 10'h000);
      wait_ev(1'b1);
      check({txd, 9'(irq)}, 10'h201);
    end
    @(posedge mclk);
    ext_sel <= 1'b0;
    reload <= 8'hff;
    for (int i = 0; i < 8; i++)
    begin
      wr(ctl_a, rc[i]);
      u_far.send(rb[i], rc[i][7] ? 10 : 9);
      rd(ctl_a, v);
      check(10'(v), 10'(re[i]));
      check(10'(irq), 10'(re[i][0]));
      rd(dat_a, v);
      check(10'(v), 10'(rdt[i]));
    end
    wr(ctl_a, 8'h10);
    u_far.glitch();
    repeat (30) @(posedge mclk);
    rd(ctl_a, v);
    check(10'(v), 10'h050);
    u_far.send(10'h1c3, 9);
    rd(ctl_a, v);
    check(10'(v), 10'h055);
    rd(dat_a, v);
    check(10'(v), 10'h0c3);
    give_verdict();
  end
endmodule
`default_nettype wire
